/* File: inc/dev_desc_pkg.sv */
// Purpose: Constants and carrier types for the device descriptor block.
// Assumes: 10 MHz clk_in, Avalon-MM register slave with word addressing.
// Notes:   Each rule below is tagged at the logic and the checks that keep it.
// Contract
// - Byte 0 holds the descriptor length, byte 1 the DEVICE type code.
// - Bytes 2-3 hold the BCD specification release, e.g. 2.10 as 210H.
// - Class zero means interfaces carry own class and run independently.
// - Class 1 to FEH names the class used for aggregate interfaces.
// - Class FFH marks a vendor-specific device class.
// - Subclass at byte 5 reads zero whenever class is zero.
// - With class not FFH only assigned subclass values are used; the block stores any written subclass.
// - Protocol at byte 6 names device-wide class protocol, read through class.
// - Protocol zero means no device-wide class protocol is in use.
// - Protocol FFH means a vendor-specific device-wide protocol.
// - Byte 7 holds endpoint zero packet size: only 8, 16, 32 or 64.
// - Bytes 8-9 hold the vendor identifier.
// - Bytes 10-11 hold the product identifier.
// - Bytes 12-13 hold the BCD device release number.
// - Every descriptor starts with its length byte then its type byte.
// - At high speed endpoint zero packet size reads 64, nothing else.
// - A high-speed capable device reports release 0200H.
package dev_desc_pkg;

	// ==========================================================
	// Descriptor layout
	localparam logic [7:0]  DESC_LENGTH      = 8'h12;
	localparam logic [7:0]  DESC_TYPE_DEVICE = 8'h01;
	localparam logic [4:0]  OFS_LENGTH       = 5'h00;
	localparam logic [4:0]  OFS_TYPE         = 5'h01;
	localparam logic [4:0]  OFS_BCD_USB      = 5'h02;
	localparam logic [4:0]  OFS_CLASS        = 5'h04;
	localparam logic [4:0]  OFS_SUBCLASS     = 5'h05;
	localparam logic [4:0]  OFS_PROTOCOL     = 5'h06;
	localparam logic [4:0]  OFS_MPS0         = 5'h07;
	localparam logic [4:0]  OFS_VENDOR       = 5'h08;
	localparam logic [4:0]  OFS_PRODUCT      = 5'h0A;
	localparam logic [4:0]  OFS_BCD_DEVICE   = 5'h0C;
	localparam logic [4:0]  OFS_LAST         = 5'h0D;

	// ==========================================================
	// Special codes and reset values
	localparam logic [7:0]  CODE_NONE        = 8'h00;
	localparam logic [7:0]  CODE_VENDOR      = 8'hFF;
	localparam logic [15:0] BCD_USB_HS       = 16'h0200;
	localparam logic [15:0] RST_BCD_USB      = 16'h0110;
	localparam logic [15:0] RST_BCD_DEVICE   = 16'h0100;
	localparam logic [7:0]  MPS_8            = 8'h08;
	localparam logic [7:0]  MPS_16           = 8'h10;
	localparam logic [7:0]  MPS_32           = 8'h20;
	localparam logic [7:0]  MPS_64           = 8'h40;

	// ==========================================================
	// Register map, word addresses
	localparam logic [2:0]  REG_CODES        = 3'h0;
	localparam logic [2:0]  REG_IDS          = 3'h1;
	localparam logic [2:0]  REG_RELEASE      = 3'h2;
	localparam logic [2:0]  REG_EP0          = 3'h3;
	localparam logic [2:0]  REG_STATUS       = 3'h4;
	localparam int          ST_HS_ACTIVE     = 0;
	localparam int          ST_BAD_BCD       = 1;
	localparam int          ST_BAD_MPS       = 2;
	localparam int          ST_SUB_FORCED    = 3;

	// Effective descriptor fields, as sent on the byte port
	typedef struct packed {
		logic [15:0] bcd_device;
		logic [15:0] product_id;
		logic [15:0] vendor_id;
		logic [7:0]  ep0_size;
		logic [7:0]  dev_protocol;
		logic [7:0]  dev_subclass;
		logic [7:0]  dev_class;
		logic [15:0] bcd_usb;
	} desc_fields_t;

	// Avalon-MM slave request
	typedef struct packed {
		logic        read;
		logic        write;
		logic [2:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} avs_req_t;

endpackage : dev_desc_pkg

/* File: hw/device_descriptor_rom.sv */
// Purpose: Device descriptor bytes 0 to 13, held in software registers.
// Assumes: Avalon-MM slave with waitrequest, word addressing, 32-bit data.
// Notes:   Byte port answers one cycle after desc_rd_in; bus answers after one wait.
`timescale 1ns/1ps

module device_descriptor_rom #(
	parameter bit HS_CAPABLE = 1'b1
) (
	input  wire logic                      clk_in,
	input  wire logic                      sys_rst_in,
	input  wire logic                      clk_en_in,
	input  wire logic                      hs_mode_in,
	input  wire dev_desc_pkg::avs_req_t    avs_req_in,
	output logic [31:0]                    avs_readdata_out,
	output logic                           avs_waitrequest_out,
	input  wire logic                      desc_rd_in,
	input  wire logic [4:0]                desc_index_in,
	output logic [7:0]                     desc_data_out,
	output logic                           desc_valid_out,
	output logic                           iface_independent_out,
	output logic                           aggregate_class_out,
	output logic                           vendor_class_out,
	output logic                           device_protocol_out,
	output logic                           vendor_protocol_out
);
	import dev_desc_pkg::*;

	// ==========================================================
	// Storage
	logic [7:0]   class_reg;
	logic [7:0]   subclass_reg;
	logic [7:0]   protocol_reg;
	logic [15:0]  vendor_reg;
	logic [15:0]  product_reg;
	logic [15:0]  bcd_device_reg;
	logic [15:0]  bcd_usb_reg;
	logic [7:0]   mps_reg;
	logic         bad_bcd_reg;
	logic         bad_mps_reg;
	logic         hs_meta_reg;
	logic         hs_sync_reg;
	logic         wait_reg;
	logic [31:0]  rdata_reg;
	logic [7:0]   data_reg;
	logic         valid_reg;
	logic [4:0]   flags_reg;
	desc_fields_t eff;
	logic         req;
	logic         wr_take;
	logic [31:0]  codes_wmerge;
	logic [31:0]  ids_wmerge;
	logic [31:0]  rel_wmerge;
	logic [31:0]  rd_next;

	assign req     = avs_req_in.read | avs_req_in.write;
	assign wr_take = clk_en_in & avs_req_in.write & ~wait_reg;

	// Merge write data over current word under byte enables
	function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] m;
		m = cur;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return m;
	endfunction : merge

	// True when every nibble is a decimal digit
	function automatic logic bcd_ok(input logic [15:0] v);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (v[i*4 +: 4] > 4'h9) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : bcd_ok

	// Only the four packet sizes endpoint zero may take
	function automatic logic mps_ok(input logic [7:0] v);
		return (v == MPS_8) || (v == MPS_16) || (v == MPS_32) || (v == MPS_64);
	endfunction : mps_ok

	// Write words merged over current contents, one per register, so that
	// no clocked process needs a blocking temporary
	assign codes_wmerge = merge({8'h00, protocol_reg, subclass_reg, class_reg},
		avs_req_in.writedata, avs_req_in.byteenable);
	assign ids_wmerge   = merge({product_reg, vendor_reg}, avs_req_in.writedata,
		avs_req_in.byteenable);
	assign rel_wmerge   = merge({bcd_usb_reg, bcd_device_reg}, avs_req_in.writedata,
		avs_req_in.byteenable);

	// ==========================================================
	// High-speed indication from the transceiver, two-stage synchroniser
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			hs_meta_reg <= 1'b0;
			hs_sync_reg <= 1'b0;
		end else if (clk_en_in) begin
			hs_meta_reg <= hs_mode_in;
			hs_sync_reg <= hs_meta_reg;
		end
	end

	// ==========================================================
	// Effective field values, with the forced cases applied
	always_comb begin
		eff              = '0;
		eff.dev_class    = class_reg;
		// Class zero pins the subclass to zero whatever software left there
		eff.dev_subclass = (class_reg == CODE_NONE) ? CODE_NONE : subclass_reg;
		eff.dev_protocol = protocol_reg;
		eff.ep0_size     = (HS_CAPABLE && hs_sync_reg) ? MPS_64 : mps_reg;
		eff.vendor_id    = vendor_reg;
		eff.product_id   = product_reg;
		eff.bcd_device   = bcd_device_reg;
		eff.bcd_usb      = HS_CAPABLE ? BCD_USB_HS : bcd_usb_reg;
	end

	// ==========================================================
	// Class codes word; subclass passes as written, software owns the
	// assigned-code table when the class is not vendor-specific
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			class_reg    <= CODE_NONE;
			subclass_reg <= CODE_NONE;
			protocol_reg <= CODE_NONE;
		end else if (wr_take && avs_req_in.address == REG_CODES) begin
			class_reg    <= codes_wmerge[7:0];
			subclass_reg <= codes_wmerge[15:8];
			protocol_reg <= codes_wmerge[23:16];
		end
	end

	// Identifier word
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			vendor_reg  <= 16'h0000;
			product_reg <= 16'h0000;
		end else if (wr_take && avs_req_in.address == REG_IDS) begin
			vendor_reg  <= ids_wmerge[15:0];
			product_reg <= ids_wmerge[31:16];
		end
	end

	// Release numbers; a half with a non-decimal nibble is refused whole
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			bcd_device_reg <= RST_BCD_DEVICE;
			bcd_usb_reg    <= RST_BCD_USB;
			bad_bcd_reg    <= 1'b0;
		end else if (wr_take && avs_req_in.address == REG_RELEASE) begin
			if (bcd_ok(rel_wmerge[15:0])) begin
				bcd_device_reg <= rel_wmerge[15:0];
			end
			if (bcd_ok(rel_wmerge[31:16])) begin
				bcd_usb_reg <= rel_wmerge[31:16];
			end
			bad_bcd_reg <= ~(bcd_ok(rel_wmerge[15:0]) & bcd_ok(rel_wmerge[31:16]));
		end
	end

	// Packet size; an illegal size leaves the old one and raises a flag
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mps_reg     <= MPS_64;
			bad_mps_reg <= 1'b0;
		end else if (wr_take && avs_req_in.address == REG_EP0 && avs_req_in.byteenable[0]) begin
			if (mps_ok(avs_req_in.writedata[7:0])) begin
				mps_reg <= avs_req_in.writedata[7:0];
			end
			bad_mps_reg <= ~mps_ok(avs_req_in.writedata[7:0]);
		end
	end

	// ==========================================================
	// Read mux; unmapped words read zero
	always_comb begin
		rd_next = 32'h0000_0000;
		unique case (avs_req_in.address)
			REG_CODES:   rd_next = {8'h00, protocol_reg, subclass_reg, class_reg};
			REG_IDS:     rd_next = {product_reg, vendor_reg};
			REG_RELEASE: rd_next = {eff.bcd_usb, bcd_device_reg};
			REG_EP0:     rd_next = {24'h000000, eff.ep0_size};
			REG_STATUS: begin
				rd_next[ST_HS_ACTIVE]  = HS_CAPABLE & hs_sync_reg;
				rd_next[ST_BAD_BCD]    = bad_bcd_reg;
				rd_next[ST_BAD_MPS]    = bad_mps_reg;
				rd_next[ST_SUB_FORCED] = (class_reg == CODE_NONE) && (subclass_reg != CODE_NONE);
			end
			default:     rd_next = 32'h0000_0000;
		endcase
	end

	// Bus handshake: one wait cycle, then a single-cycle answer.
	// Costs a cycle per access but keeps read data straight from a flop.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else if (clk_en_in) begin
			wait_reg <= ~(req & wait_reg);
			if (avs_req_in.read && wait_reg) begin
				rdata_reg <= rd_next;
			end
		end
	end

	// ==========================================================
	// Descriptor byte port, two-byte fields low byte first
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			data_reg  <= 8'h00;
			valid_reg <= 1'b0;
		end else if (clk_en_in) begin
			valid_reg <= desc_rd_in && (desc_index_in <= OFS_LAST);
			if (desc_rd_in) begin
				unique case (desc_index_in)
					OFS_LENGTH:         data_reg <= DESC_LENGTH;
					OFS_TYPE:           data_reg <= DESC_TYPE_DEVICE;
					OFS_BCD_USB:        data_reg <= eff.bcd_usb[7:0];
					OFS_BCD_USB + 5'h1: data_reg <= eff.bcd_usb[15:8];
					OFS_CLASS:          data_reg <= eff.dev_class;
					OFS_SUBCLASS:       data_reg <= eff.dev_subclass;
					OFS_PROTOCOL:       data_reg <= eff.dev_protocol;
					OFS_MPS0:           data_reg <= eff.ep0_size;
					OFS_VENDOR:         data_reg <= eff.vendor_id[7:0];
					OFS_VENDOR + 5'h1:  data_reg <= eff.vendor_id[15:8];
					OFS_PRODUCT:        data_reg <= eff.product_id[7:0];
					OFS_PRODUCT + 5'h1: data_reg <= eff.product_id[15:8];
					OFS_BCD_DEVICE:     data_reg <= eff.bcd_device[7:0];
					OFS_LAST:           data_reg <= eff.bcd_device[15:8];
					default:            data_reg <= 8'h00;
				endcase
			end
		end
	end

	// ==========================================================
	// Decoded meaning of class and protocol codes for the rest of the device
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			flags_reg <= 5'b00001;
		end else if (clk_en_in) begin
			flags_reg[0] <= (eff.dev_class == CODE_NONE);
			flags_reg[1] <= (eff.dev_class != CODE_NONE) && (eff.dev_class != CODE_VENDOR);
			flags_reg[2] <= (eff.dev_class == CODE_VENDOR);
			flags_reg[3] <= (eff.dev_protocol != CODE_NONE);
			flags_reg[4] <= (eff.dev_protocol == CODE_VENDOR);
		end
	end

	assign avs_readdata_out      = rdata_reg;
	assign avs_waitrequest_out   = wait_reg;
	assign desc_data_out         = data_reg;
	assign desc_valid_out        = valid_reg;
	assign iface_independent_out = flags_reg[0];
	assign aggregate_class_out   = flags_reg[1];
	assign vendor_class_out      = flags_reg[2];
	assign device_protocol_out   = flags_reg[3];
	assign vendor_protocol_out   = flags_reg[4];

	// ==========================================================
	// Checks
	a_head_bytes: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && desc_rd_in && desc_index_in <= OFS_TYPE |=>
		desc_valid_out && desc_data_out ==
		(($past(desc_index_in) == OFS_LENGTH) ? DESC_LENGTH : DESC_TYPE_DEVICE))
		else $error("length or type byte wrong");

	a_sub_zeroed: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && desc_rd_in && desc_index_in == OFS_SUBCLASS && class_reg == CODE_NONE
		|=> desc_data_out == CODE_NONE)
		else $error("subclass not zero under class zero");

	a_hs_size: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && hs_sync_reg && desc_rd_in && desc_index_in == OFS_MPS0
		|=> !HS_CAPABLE || desc_data_out == MPS_64)
		else $error("high speed packet size not 64");

	a_size_legal: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		mps_ok(mps_reg))
		else $error("illegal endpoint zero size");

	a_size_refused: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wr_take && avs_req_in.address == REG_EP0 && avs_req_in.byteenable[0] &&
		!mps_ok(avs_req_in.writedata[7:0]) |=> $stable(mps_reg) && bad_mps_reg)
		else $error("illegal size not refused");

	a_usb_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && desc_rd_in && desc_index_in == OFS_BCD_USB + 5'h1 && HS_CAPABLE
		|=> desc_data_out == BCD_USB_HS[15:8])
		else $error("release high byte wrong");

	a_vendor_lsb: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && desc_rd_in && desc_index_in == OFS_VENDOR
		|=> desc_data_out == $past(vendor_reg[7:0]))
		else $error("vendor low byte not first");

	a_class_vendor: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && class_reg == CODE_VENDOR ##1 clk_en_in |->
		vendor_class_out && !aggregate_class_out && !iface_independent_out)
		else $error("vendor class flags wrong");

	a_proto_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && protocol_reg == CODE_NONE |=> !device_protocol_out && !vendor_protocol_out)
		else $error("protocol zero decoded wrong");

	a_bcd_kept: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		bcd_ok(bcd_device_reg) && bcd_ok(bcd_usb_reg))
		else $error("non-decimal release stored");

	a_bus_answer: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && req && wait_reg |=> !wait_reg ##1 (wait_reg || !$past(clk_en_in)))
		else $error("bus answer timing wrong");

	// Read data is caught on the edge that drops waitrequest and stands through the answer
	a_read_stands: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && avs_req_in.read && wait_reg |=> avs_readdata_out == $past(rd_next))
		else $error("read data not registered");

	a_bcd_refused: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wr_take && avs_req_in.address == REG_RELEASE && !bcd_ok(rel_wmerge[15:0])
		|=> $stable(bcd_device_reg) && bad_bcd_reg)
		else $error("non-decimal release not refused");

	a_index_refused: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && desc_rd_in && desc_index_in > OFS_LAST
		|=> !desc_valid_out && desc_data_out == 8'h00)
		else $error("index past end answered");

	a_valid_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && !desc_rd_in |=> !desc_valid_out)
		else $error("byte valid without request");

	a_iface_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && class_reg == CODE_NONE
		|=> iface_independent_out && !aggregate_class_out && !vendor_class_out)
		else $error("class zero decoded wrong");

	a_aggregate_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && class_reg != CODE_NONE && class_reg != CODE_VENDOR
		|=> aggregate_class_out && !iface_independent_out && !vendor_class_out)
		else $error("aggregate class decoded wrong");

	a_proto_vendor: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && protocol_reg == CODE_VENDOR |=> vendor_protocol_out && device_protocol_out)
		else $error("vendor protocol decoded wrong");

	a_product_lsb: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && desc_rd_in && desc_index_in == OFS_PRODUCT
		|=> desc_data_out == $past(product_reg[7:0]))
		else $error("product low byte not first");

	a_release_lsb: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && desc_rd_in && desc_index_in == OFS_BCD_DEVICE
		|=> desc_data_out == $past(bcd_device_reg[7:0]))
		else $error("device release low byte not first");

endmodule : device_descriptor_rom

/* File: sim/desc_host.sv */
// Purpose: Host side reader of descriptor bytes for the bench.
// Assumes: Byte port shows a request's answer in the cycle after it.
// Notes:   Index lines are inverted when idle, so a stale index never matches.
`timescale 1ns/1ps

module desc_host (
	input  wire logic       clk_in,
	output logic            desc_rd_out,
	output logic [4:0]      desc_index_out,
	input  wire logic [7:0] desc_data_in,
	input  wire logic       desc_valid_in
);
	logic [7:0] cap_data  [0:15];
	logic       cap_valid [0:15];

	// ==========================================================
	// Idle levels at time zero
	initial begin
		desc_rd_out    = 1'h0;
		desc_index_out = 5'h00;
	end

	// One request per edge; each answer stands one cycle, so catch it there
	task automatic burst(input int first, input int n);
		for (int k = 0; k <= n; k++) begin
			@(posedge clk_in);
			if (k < n) begin
				desc_rd_out    <= 1'h1;
				desc_index_out <= 5'(first + k);
			end else begin
				desc_rd_out    <= 1'h0;
				desc_index_out <= ~desc_index_out;
			end
			@(negedge clk_in);
			if (k > 0) begin
				cap_data[k-1]  = desc_data_in;
				cap_valid[k-1] = desc_valid_in;
			end
		end
	endtask : burst

endmodule : desc_host

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the device descriptor block.
// Assumes: HS_CAPABLE left at 1; clk_en_in high except one frozen stretch.
// Notes:   Reset walk first, then table rows, refusals, speed change and mid-run reset.
`timescale 1ns/1ps

module tb_top;
	import dev_desc_pkg::*;

	typedef struct {
		logic [2:0]  a;
		logic [31:0] wd;
		logic [4:0]  ix;
		logic [7:0]  eb;
		logic [4:0]  fl;
	} row_t;

	logic        clk_in;
	logic        sys_rst_in;
	logic        en;
	logic        hs_mode_in;
	avs_req_t    req;
	logic [31:0] rdata;
	logic        wait_req;
	logic        rd;
	logic [4:0]  idx;
	logic [7:0]  data;
	logic        valid;
	logic [4:0]  flags;
	logic [31:0] rv;
	int          err_count;
	int          total_checks;
	row_t        rows [0:19];
	logic [7:0]  walk [0:13];

	device_descriptor_rom dut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(en), .hs_mode_in(hs_mode_in),
		.avs_req_in(req), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
		.desc_rd_in(rd), .desc_index_in(idx), .desc_data_out(data), .desc_valid_out(valid),
		.iface_independent_out(flags[4]), .aggregate_class_out(flags[3]),
		.vendor_class_out(flags[2]), .device_protocol_out(flags[1]),
		.vendor_protocol_out(flags[0])
	);

	desc_host host (
		.clk_in(clk_in), .desc_rd_out(rd), .desc_index_out(idx),
		.desc_data_in(data), .desc_valid_in(valid)
	);

	// ==========================================================
	// Clock and watchdog; the run needs well under a thousand cycles
	initial begin
		clk_in = 1'h0;
		forever #50 clk_in = ~clk_in;
	end

	initial begin
		#(100 * 5000);
		err_count++;
		results();
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: %s got %0h expected %0h", $time, m, g, e);
		end
	endtask : chk

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
		input logic [3:0] be = 4'hF);
		int n;
		n = 0;
		@(posedge clk_in);
		req <= '{read: ~w, write: w, address: a, byteenable: be, writedata: d};
		do begin
			@(posedge clk_in);
			n++;
		end while (wait_req !== 1'h0);
		chk(n, 32'h2, "bus answer latency");
		rv = rdata;
		req <= '{default: '0};
	endtask : bus

	task automatic byte_at(input logic [4:0] ix, input logic [7:0] e);
		host.burst(int'(ix), 1);
		chk({23'h0, host.cap_valid[0], host.cap_data[0]}, {23'h0, 1'h1, e}, "byte");
	endtask : byte_at

	// Back-to-back read of all fourteen bytes after a reset
	task automatic walk_all();
		host.burst(0, 14);
		for (int i = 0; i < 14; i++) begin
			chk({23'h0, host.cap_valid[i], host.cap_data[i]}, {23'h0, 1'h1, walk[i]}, "walk");
		end
		chk({27'h0, flags}, 32'h10, "reset flags");
	endtask : walk_all

	task automatic results();
		if (err_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results

	// ==========================================================
	// Main sequence
	initial begin
		err_count    = 0;
		total_checks = 0;
		sys_rst_in   = 1'h1;
		en           = 1'h1;
		hs_mode_in   = 1'h0;
		req          = '{default: '0};
		walk = '{DESC_LENGTH, DESC_TYPE_DEVICE, BCD_USB_HS[7:0], BCD_USB_HS[15:8], CODE_NONE,
			CODE_NONE, CODE_NONE, MPS_64, 8'h00, 8'h00, 8'h00, 8'h00, RST_BCD_DEVICE[7:0],
			RST_BCD_DEVICE[15:8]};
		rows[0]  = '{3'h5, 32'hFFFFFFFF, 5'h00, 8'h12, 5'h10};
		rows[1]  = '{3'h5, 32'h00000000, 5'h01, 8'h01, 5'h10};
		rows[2]  = '{3'h0, 32'h00000500, 5'h05, 8'h00, 5'h10};
		rows[3]  = '{3'h0, 32'h00020103, 5'h04, 8'h03, 5'h0A};
		rows[4]  = '{3'h0, 32'h00020103, 5'h06, 8'h02, 5'h0A};
		rows[5]  = '{3'h0, 32'h000001FE, 5'h05, 8'h01, 5'h08};
		rows[6]  = '{3'h0, 32'h00FF07FF, 5'h06, 8'hFF, 5'h07};
		rows[7]  = '{3'h0, 32'h00000001, 5'h04, 8'h01, 5'h08};
		rows[8]  = '{3'h1, 32'h56781234, 5'h08, 8'h34, 5'h08};
		rows[9]  = '{3'h1, 32'h56781234, 5'h09, 8'h12, 5'h08};
		rows[10] = '{3'h1, 32'h56781234, 5'h0A, 8'h78, 5'h08};
		rows[11] = '{3'h1, 32'h56781234, 5'h0B, 8'h56, 5'h08};
		rows[12] = '{3'h2, 32'h00000123, 5'h0C, 8'h23, 5'h08};
		rows[13] = '{3'h2, 32'h00000123, 5'h0D, 8'h01, 5'h08};
		rows[14] = '{3'h2, 32'h00000123, 5'h02, 8'h00, 5'h08};
		rows[15] = '{3'h2, 32'h00000123, 5'h03, 8'h02, 5'h08};
		rows[16] = '{3'h3, 32'h00000008, 5'h07, 8'h08, 5'h08};
		rows[17] = '{3'h3, 32'h00000010, 5'h07, 8'h10, 5'h08};
		rows[18] = '{3'h3, 32'h00000020, 5'h07, 8'h20, 5'h08};
		rows[19] = '{3'h3, 32'h00000040, 5'h07, 8'h40, 5'h08};
		repeat (10) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		walk_all();
		// Table of ordinary writes, each followed by one byte read
		foreach (rows[i]) begin
			bus(1'h1, rows[i].a, rows[i].wd);
			byte_at(rows[i].ix, rows[i].eb);
			chk({27'h0, flags}, {27'h0, rows[i].fl}, "class flags");
		end
		// Register readback of the codes and identifier words
		bus(1'h0, REG_CODES, 32'h0);
		chk(rv & 32'h00FFFFFF, 32'h00000001, "codes readback");
		bus(1'h0, REG_IDS, 32'h0);
		chk(rv, 32'h56781234, "ids readback");
		// Byte enables limit a write to the vendor half, then an unmapped read
		bus(1'h1, REG_IDS, 32'hAAAA9999, 4'h3);
		byte_at(OFS_VENDOR, 8'h99);
		byte_at(OFS_PRODUCT, 8'h78);
		bus(1'h0, 3'h6, 32'h0);
		chk(rv, 32'h0, "unmapped read");
		// Illegal packet size and bad BCD are refused
		bus(1'h1, REG_EP0, 32'h00000011);
		byte_at(OFS_MPS0, MPS_64);
		bus(1'h0, REG_STATUS, 32'h0);
		chk({31'h0, rv[ST_BAD_MPS]}, 32'h1, "bad size flag");
		bus(1'h1, REG_RELEASE, 32'h0000012A);
		byte_at(OFS_BCD_DEVICE, 8'h23);
		bus(1'h0, REG_STATUS, 32'h0);
		chk({31'h0, rv[ST_BAD_BCD]}, 32'h1, "bad bcd flag");
		// Index past the end gives no valid byte
		host.burst(14, 1);
		chk({31'h0, host.cap_valid[0]}, 32'h0, "index 14 refused");
		// High speed forces 64 bytes, leaving it restores the stored size
		bus(1'h1, REG_EP0, 32'h00000008);
		@(posedge clk_in);
		hs_mode_in <= 1'h1;
		repeat (5) @(posedge clk_in);
		byte_at(OFS_MPS0, MPS_64);
		bus(1'h0, REG_EP0, 32'h0);
		chk(rv & 32'hFF, 32'h40, "ep0 readback at hs");
		bus(1'h0, REG_STATUS, 32'h0);
		chk({31'h0, rv[ST_HS_ACTIVE]}, 32'h1, "hs status");
		byte_at(OFS_BCD_USB + 5'h01, BCD_USB_HS[15:8]);
		@(posedge clk_in);
		hs_mode_in <= 1'h0;
		repeat (5) @(posedge clk_in);
		byte_at(OFS_MPS0, MPS_8);
		// Clock enable low freezes the byte port, so no answer comes
		@(posedge clk_in);
		en <= 1'h0;
		host.burst(0, 1);
		chk({31'h0, host.cap_valid[0]}, 32'h0, "frozen byte port");
		@(posedge clk_in);
		en <= 1'h1;
		// Mid-run reset restores every field
		@(posedge clk_in);
		sys_rst_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		walk_all();
		results();
	end

endmodule : tb_top
